// File: rtl/clk_sequencer.sv
// two-speed start-up and fail-safe clock sequencer with an APB register file
module clk_sequencer
  import clk_seq_pkg::*;
#(
  parameter int ADDR_W     = 8,
  parameter int OST_CYCLES = OST_CYCLES_DEFAULT,
  parameter int LF_DIV     = LF_DIV_DEFAULT
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic [31:0]            prdata,
  input  wire logic              ext_clk,
  input  wire logic              tosc_clk,
  input  wire logic              internal_osc_clk,
  input  wire logic              lfosc_clk,
  input  wire logic              sleep_enter,
  input  wire logic              wake,
  output logic [1:0]             sys_clk_sel,
  output logic                   sys_clk_hold,
  output logic [3:0]             internal_osc_freq_sel,
  output logic                   startup_done_flag,
  output logic                   osc_fail_irq
);

  localparam int OST_W = $clog2(OST_CYCLES + 1);

  if (ADDR_W < 5) begin
    $error("ADDR_W too small for the register map");
  end
  if (OST_CYCLES < 1 || OST_CYCLES > 4096) begin
    $error("OST_CYCLES out of range");
  end

  typedef struct packed {
    seq_state_t       st;
    logic [OST_W-1:0] ost_cnt;
    logic [1:0]       css;
    logic [3:0]       ifs;
    logic             two_spd;
    logic             fcm_en;
    logic [2:0]       mode;
    logic             flag;
    logic             irq_en;
    logic             done;
    logic             fail_safe;
    logic [1:0]       sel;
    logic             hold;
    logic             irq;
    logic             int_d;
    logic             src_d;
    logic             pready;
    logic             pslverr;
    logic [31:0]      prdata;
  } regs_t;

  regs_t q, n;

  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    logic [7:0] o;
    o = 8'(a);
    addr_hit = (ADDR_W <= 8 || a[ADDR_W-1:0] == ADDR_W'(o)) &&
               (o == OFS_CTRL || o == OFS_CONFIG || o == OFS_STATUS ||
                o == OFS_FLAGS || o == OFS_IRQEN);
  endfunction

  function automatic logic is_crystal(input logic [2:0] m);
    is_crystal = (m == MODE_LP) || (m == MODE_XT) || (m == MODE_HS);
  endfunction

  logic       src_lvl;
  logic       src_fall;
  logic       int_fall;
  logic       wr_en;
  logic       css_chg;
  logic       mon_en;
  logic       det_fail;
  logic       fail_evt;
  logic [7:0] ofs;

  // monitor sees the selected external source, enabled only in ST_WFALL, ST_HOLD and ST_EXT with fcm_en set
  assign src_lvl = (q.css == CSS_TOSC) ? tosc_clk : ext_clk;
  assign mon_en  = q.fcm_en &&
                   (q.st == ST_WFALL || q.st == ST_HOLD || q.st == ST_EXT);

  fail_detector #(
    .LF_DIV(LF_DIV)
  ) u_det (
    .pclk     (pclk),
    .presetn  (presetn),
    .enable   (mon_en),
    .src_level(src_lvl),
    .lf_level (lfosc_clk),
    .fail_q   (det_fail)
  );

  always_comb begin
    n         = q;
    ofs       = 8'(paddr);
    src_fall  = q.src_d & ~src_lvl;
    int_fall  = q.int_d & ~internal_osc_clk;
    n.src_d   = src_lvl;
    n.int_d   = internal_osc_clk;
    n.pready  = 1'b0;
    n.pslverr = 1'b0;
    css_chg   = 1'b0;
    fail_evt  = det_fail && mon_en;

    // no wait state: data prepared in setup, answered in the first access cycle
    if (psel && !penable && !q.pready) begin
      n.pready  = 1'b1;
      n.pslverr = !addr_hit(paddr);
      n.prdata  = 32'h0000_0000;
      if (!pwrite && addr_hit(paddr)) begin
        unique case (ofs)
          OFS_CTRL: begin
            n.prdata[CTRL_CSS_LSB +: 2] = q.css;
            n.prdata[CTRL_IFS_LSB +: 4] = q.ifs;
          end
          OFS_CONFIG: begin
            n.prdata[CFG_TWO_SPD]       = q.two_spd;
            n.prdata[CFG_FCM_EN]        = q.fcm_en;
            n.prdata[CFG_MODE_LSB +: 3] = q.mode;
          end
          OFS_STATUS: begin
            n.prdata[STAT_DONE]         = q.done;
            n.prdata[STAT_FAILSAFE]     = q.fail_safe;
            n.prdata[STAT_SEL_LSB +: 2] = q.sel;
            n.prdata[STAT_HOLD]         = q.hold;
          end
          OFS_FLAGS: n.prdata[FLAG_OSC_FAIL] = q.flag;
          default:   n.prdata[IRQEN_OSC]     = q.irq_en;
        endcase
      end
    end

    wr_en = psel && penable && pwrite && q.pready && !q.pslverr;
    if (wr_en) begin
      unique case (ofs)
        OFS_CTRL: begin
          n.css   = pwdata[CTRL_CSS_LSB +: 2];
          n.ifs   = pwdata[CTRL_IFS_LSB +: 4];
          css_chg = (pwdata[CTRL_CSS_LSB +: 2] != q.css);
        end
        OFS_CONFIG: begin
          n.two_spd = pwdata[CFG_TWO_SPD];
          n.fcm_en  = pwdata[CFG_FCM_EN];
          n.mode    = pwdata[CFG_MODE_LSB +: 3];
        end
        OFS_FLAGS: begin
          if (pwdata[FLAG_OSC_FAIL]) n.flag = 1'b0;
        end
        OFS_IRQEN: n.irq_en = pwdata[IRQEN_OSC];
        default: ;
      endcase
    end

    unique case (q.st)
      ST_IDLE: begin
        n.sel  = SEL_INT;
        n.hold = 1'b0;
        if (q.css == CSS_TOSC) begin
          n.st      = ST_OST;
          n.ost_cnt = '0;
        end else if (q.css == CSS_PRIMARY && (is_crystal(q.mode))) begin
          n.st      = ST_OST;
          n.ost_cnt = '0;
          // without two-speed or the fail monitor the core waits out the timer unclocked
          n.hold    = !(q.two_spd || q.fcm_en);
        end else if (q.css == CSS_PRIMARY && q.mode != MODE_INT) begin
          n.st   = ST_EXT;
          n.done = 1'b1;
          n.sel  = SEL_EXT;
        end
      end
      ST_OST: begin
        if (src_fall) begin
          n.ost_cnt = q.ost_cnt + OST_W'(1);
        end
        if (q.ost_cnt == OST_W'(OST_CYCLES)) begin
          n.st = ST_WFALL;
        end
      end
      ST_WFALL: begin
        if (int_fall) begin
          n.st   = ST_HOLD;
          n.done = 1'b1;
          n.hold = 1'b1;
        end
      end
      ST_HOLD: begin
        if (src_fall) begin
          n.st        = ST_EXT;
          n.hold      = 1'b0;
          n.sel       = (q.css == CSS_TOSC) ? SEL_TOSC : SEL_EXT;
          n.fail_safe = 1'b0;
        end
      end
      ST_EXT: ;
      ST_FAIL: n.sel = SEL_INT;
      ST_SLEEP: begin
        if (wake) begin
          n.st = ST_IDLE;
        end
      end
    endcase

    if (fail_evt) begin
      n.st        = ST_FAIL;
      n.fail_safe = 1'b1;
      n.sel       = SEL_INT;
      n.hold      = 1'b0;
      n.done      = 1'b0;
    end
    if (css_chg) begin
      n.st        = ST_IDLE;
      n.fail_safe = 1'b0;
      n.done      = 1'b0;
      n.sel       = SEL_INT;
      n.hold      = 1'b0;
    end
    if (sleep_enter) begin
      n.st        = ST_SLEEP;
      n.fail_safe = 1'b0;
      n.done      = 1'b0;
      n.sel       = SEL_INT;
      n.hold      = 1'b0;
    end
    // hardware set wins over a software clear in the same cycle
    if (fail_evt) begin
      n.flag = 1'b1;
    end
    n.irq = n.flag && n.irq_en;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q         <= '0;
      q.st      <= ST_IDLE;
      q.css     <= CSS_RESET;
      q.ifs     <= IFS_RESET;
      q.two_spd <= TWO_SPD_RESET;
      q.fcm_en  <= FCM_EN_RESET;
      q.mode    <= MODE_RESET;
      q.sel     <= SEL_INT;
    end else begin
      q <= n;
    end
  end

  assign pready            = q.pready;
  assign pslverr           = q.pslverr;
  assign prdata            = q.prdata;
  assign sys_clk_sel       = q.sel;
  assign sys_clk_hold      = q.hold;
  assign internal_osc_freq_sel   = q.ifs;
  assign startup_done_flag = q.done;
  assign osc_fail_irq      = q.irq;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_ost_bound: assert property (q.st == ST_OST |-> q.ost_cnt <= OST_W'(OST_CYCLES))
    else $error("start-up count ran past its limit");
  chk_ost_expire: assert property (
    q.st == ST_WFALL && $past(q.st) == ST_OST |-> $past(q.ost_cnt) == OST_W'(OST_CYCLES))
    else $error("start-up timer left early");
  chk_done_on_fall: assert property (
    q.st == ST_WFALL && int_fall && !sleep_enter && !css_chg && !fail_evt |=>
    q.done && q.hold)
    else $error("done flag not set on internal falling edge");
  chk_hold_switch: assert property (
    q.st == ST_HOLD && src_fall && !sleep_enter && !css_chg && !fail_evt |=>
    !q.hold && q.sel != SEL_INT)
    else $error("clock not handed to external source");
  chk_fail_reaction: assert property (fail_evt |=> q.flag && q.sel == SEL_INT)
    else $error("failure did not set flag and fall back");
  chk_fail_sticks: assert property (
    q.st == ST_FAIL && !css_chg && !sleep_enter |=> q.st == ST_FAIL && q.sel == SEL_INT)
    else $error("left fail-safe without a restart");
  chk_sleep_abort: assert property (sleep_enter |=> q.st == ST_SLEEP && !q.done)
    else $error("sleep did not abort start-up");
  // external clock and RC modes skip the timer, so they may switch one cycle later
  chk_css_restart: assert property (
    css_chg && !sleep_enter |=> q.st == ST_IDLE && !q.fail_safe && q.sel == SEL_INT ##1
    q.sel == SEL_INT || q.st == ST_EXT && !is_crystal(q.mode))
    else $error("source change did not restart");
  chk_irq_gate: assert property (q.irq == (q.flag && q.irq_en))
    else $error("interrupt does not follow flag and enable");
  chk_mon_gated: assert property (!q.fcm_en |=> !det_fail)
    else $error("monitor acted while disabled");

  cov_reach_ext: cover property (q.st == ST_HOLD ##1 q.st == ST_EXT);
  cov_fail: cover property (q.st == ST_EXT ##1 q.st == ST_FAIL);
  cov_sleep_wake: cover property (q.st == ST_SLEEP ##[1:20] q.st == ST_IDLE);

endmodule

// File: pkg/clk_seq_pkg.sv
// constants, register map and state types for the clock sequencer
package clk_seq_pkg;

  // bus register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_CONFIG = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_FLAGS  = 8'h0C;
  localparam logic [7:0] OFS_IRQEN  = 8'h10;

  // field positions
  localparam int CTRL_CSS_LSB  = 0;
  localparam int CTRL_IFS_LSB  = 4;
  localparam int CFG_TWO_SPD   = 0;
  localparam int CFG_FCM_EN    = 1;
  localparam int CFG_MODE_LSB  = 4;
  localparam int STAT_DONE     = 0;
  localparam int STAT_FAILSAFE = 1;
  localparam int STAT_SEL_LSB  = 2;
  localparam int STAT_HOLD     = 4;
  localparam int FLAG_OSC_FAIL = 0;
  localparam int IRQEN_OSC     = 0;

  // values after reset
  localparam logic [3:0] IFS_RESET     = 4'h7;
  localparam logic [1:0] CSS_RESET     = 2'h0;
  localparam logic [2:0] MODE_RESET    = 3'h1;
  localparam logic       TWO_SPD_RESET = 1'b1;
  localparam logic       FCM_EN_RESET  = 1'b1;

  // clock source select codes
  localparam logic [1:0] CSS_PRIMARY = 2'h0;
  localparam logic [1:0] CSS_TOSC    = 2'h1;

  // oscillator mode codes; codes at or above MODE_EC_MIN are external clock
  localparam logic [2:0] MODE_LP     = 3'h0;
  localparam logic [2:0] MODE_XT     = 3'h1;
  localparam logic [2:0] MODE_HS     = 3'h2;
  localparam logic [2:0] MODE_RC     = 3'h3;
  localparam logic [2:0] MODE_INT    = 3'h4;
  localparam logic [2:0] MODE_EC_MIN = 3'h5;

  // system clock source select output codes
  localparam logic [1:0] SEL_INT  = 2'h0;
  localparam logic [1:0] SEL_EXT  = 2'h1;
  localparam logic [1:0] SEL_TOSC = 2'h2;

  // counts
  localparam int OST_CYCLES_DEFAULT = 1024;
  localparam int LF_DIV_DEFAULT     = 64;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_OST   = 3'b001,
    ST_WFALL = 3'b011,
    ST_HOLD  = 3'b010,
    ST_EXT   = 3'b110,
    ST_FAIL  = 3'b111,
    ST_SLEEP = 3'b100
  } seq_state_t;

endpackage

// File: rtl/fail_detector.sv
// external clock fail detector against the divided low-frequency oscillator
module fail_detector
  import clk_seq_pkg::*;
#(
  parameter int LF_DIV = LF_DIV_DEFAULT
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic enable,
  input  wire logic src_level,
  input  wire logic lf_level,
  output logic      fail_q
);

  localparam int HALF  = LF_DIV / 2;
  localparam int CNT_W = (HALF > 1) ? $clog2(HALF) : 1;

  // refused at elaboration: the sample clock toggles every LF_DIV/2 rises
  if (LF_DIV < 2 || (LF_DIV % 2) != 0) begin
    $error("LF_DIV must be even and at least 2");
  end

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             lf_d;
    logic             src_d;
    logic             samp;
    logic             latch;
    logic             fail;
  } det_t;

  det_t q, n;
  logic lf_rise;
  logic src_fall;

  always_comb begin
    n        = q;
    lf_rise  = lf_level & ~q.lf_d;
    src_fall = q.src_d & ~src_level;
    n.lf_d   = lf_level;
    n.src_d  = src_level;
    n.fail   = 1'b0;
    if (!enable) begin
      n.cnt   = '0;
      n.samp  = 1'b0;
      n.latch = 1'b1;
    end else begin
      if (lf_rise) begin
        if (q.cnt == CNT_W'(HALF - 1)) begin
          n.cnt  = '0;
          n.samp = ~q.samp;
          if (!q.samp) begin
            n.latch = 1'b0;
          end else if (!q.latch && !src_fall) begin
            n.fail = 1'b1;
          end
        end else begin
          n.cnt = q.cnt + CNT_W'(1);
        end
      end
      // set beats clear when both land together
      if (src_fall) begin
        n.latch = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '{cnt: '0, lf_d: 1'b0, src_d: 1'b0, samp: 1'b0, latch: 1'b1, fail: 1'b0};
    end else begin
      q <= n;
    end
  end

  assign fail_q = q.fail;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_fail_needs_gap: assert property (q.fail |-> !$past(q.latch))
    else $error("fail raised although an external falling edge was seen");
  chk_latch_set_edge: assert property (enable && src_fall |=> q.latch)
    else $error("latch not set by external falling edge");

endmodule

// File: test/osc_model.sv
// far-side oscillator model: crystal, timer crystal, internal and low-frequency sources
module osc_model (
  input  wire logic       pclk,
  input  wire logic       ext_run,
  input  wire logic       tosc_run,
  input  wire logic [2:0] ext_half,
  output logic            ext_clk,
  output logic            tosc_clk,
  output logic            internal_osc_clk,
  output logic            lfosc_clk
);
  timeunit 1ns;
  timeprecision 100ps;
  int ec = 0;
  int tc = 0;
  int ic = 0;
  int lc = 0;
  initial begin
    ext_clk = 1'b0;
    tosc_clk = 1'b0;
    internal_osc_clk = 1'b0;
    lfosc_clk = 1'b0;
  end
  // a dead crystal freezes at its last level instead of toggling
  always @(posedge pclk) begin
    ec = (ec + 1 >= int'(ext_half)) ? 0 : ec + 1;
    tc = (tc + 1 >= 3) ? 0 : tc + 1;
    ic = (ic + 1 >= 3) ? 0 : ic + 1;
    lc = (lc + 1 >= 2) ? 0 : lc + 1;
    if (ec == 0 && ext_run) ext_clk <= !ext_clk;
    if (tc == 0 && tosc_run) tosc_clk <= !tosc_clk;
    if (ic == 0) internal_osc_clk <= !internal_osc_clk;
    if (lc == 0) lfosc_clk <= !lfosc_clk;
  end
endmodule

// File: test/tb_two_speed_startup_fail_safe_clock.sv
// self-checking bench for the clock sequencer over its register bus
`define CHK(a, b, m) begin tests_run++; if ((a) !== (b)) begin bad_count++; \
  $display("CHECK FAILED t=%0t %s", $time, m); end end
module tb_two_speed_startup_fail_safe_clock;
  import clk_seq_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int OST_N = 8;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0;
  logic        ext_run = 1, tosc_run = 1, sleep_enter = 0, wake = 0, hold_seen = 0;
  logic [2:0]  ext_half = 3'h2;
  logic        pready, pslverr, ext_clk, tosc_clk, internal_osc_clk, lfosc_clk;
  logic        sys_clk_hold, startup_done_flag, osc_fail_irq;
  logic [31:0] prdata;
  logic [1:0]  sys_clk_sel;
  logic [3:0]  internal_osc_freq_sel, ifs;
  logic [32:0] exp_q[$];
  logic [7:0]  cfg[6] = '{8'h03, 8'h23, 8'h33, 8'h53, 8'h12, 8'h10};
  int          bad_count = 0, tests_run = 0, ext_falls = 0, n;

  clk_sequencer #(.OST_CYCLES(OST_N), .LF_DIV(4)) clk_sequencer_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .ext_clk(ext_clk), .tosc_clk(tosc_clk), .internal_osc_clk(internal_osc_clk), .lfosc_clk(lfosc_clk),
    .sleep_enter(sleep_enter), .wake(wake), .sys_clk_sel(sys_clk_sel),
    .sys_clk_hold(sys_clk_hold), .internal_osc_freq_sel(internal_osc_freq_sel),
    .startup_done_flag(startup_done_flag), .osc_fail_irq(osc_fail_irq));
  osc_model osc_model_i (
    .pclk(pclk), .ext_run(ext_run), .tosc_run(tosc_run), .ext_half(ext_half),
    .ext_clk(ext_clk), .tosc_clk(tosc_clk), .internal_osc_clk(internal_osc_clk), .lfosc_clk(lfosc_clk));

  always #12.5 pclk = ~pclk;
  always @(negedge ext_clk) ext_falls++;
  always @(posedge pclk) if (sys_clk_hold === 1'b1) hold_seen = 1'b1;
  // watcher: every completed read takes the oldest noted expectation
  always @(posedge pclk) if (psel && penable && pready && !pwrite) begin
    if (exp_q.size() == 0) `CHK(1'b0, 1'b1, "read without expectation")
    else `CHK({pslverr, prdata}, exp_q.pop_front(), "read data")
  end

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a wait for the answer
    do begin @(posedge pclk); end while (pready !== 1'b1);
    if (w) `CHK(pslverr, 1'b0, "write refused")
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic wait_sel(input logic [1:0] v, input int lim);
    n = 0;
    do begin @(posedge pclk); n++; end while (sys_clk_sel !== v && n < lim);
    `CHK(sys_clk_sel, v, "clock select wait")
  endtask
  task automatic pulse(input logic up);
    @(posedge pclk);
    if (up) wake <= 1'b1;
    else sleep_enter <= 1'b1;
    @(posedge pclk);
    wake <= 1'b0;
    sleep_enter <= 1'b0;
  endtask

  initial begin
    fork begin
      #500000;
      bad_count++;
      $display("CHECK FAILED t=%0t watchdog expired", $time);
      final_report();
    end join_none
    void'($urandom(97265));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    ext_falls = 0;
    `CHK(internal_osc_freq_sel, IFS_RESET, "freq select after reset")
    rd(OFS_CTRL, 33'h70);
    rd(OFS_CONFIG, 33'h13);
    rd(OFS_STATUS, 33'h0);
    rd(OFS_FLAGS, 33'h0);
    rd(OFS_IRQEN, 33'h0);
    rd(8'h14, 33'h1_0000_0000);
    $display("test reset values done");
    n = 0;
    do begin @(posedge pclk); n++; end while (startup_done_flag !== 1'b1 && n < 400);
    `CHK(ext_falls >= OST_N && ext_falls <= OST_N + 4, 1'b1, "start-up count")
    wait_sel(SEL_EXT, 40);
    `CHK({hold_seen, sys_clk_hold}, 2'b10, "hold before switch")
    rd(OFS_STATUS, 33'h5);
    $display("test two-speed start-up done");
    ifs = 4'($urandom);
    apb(1'b1, OFS_CTRL, {24'h0, ifs, 4'h0});
    apb(1'b1, OFS_IRQEN, 32'h1);
    `CHK(internal_osc_freq_sel, ifs, "fallback frequency")
    ext_run <= 1'b0;
    wait_sel(SEL_INT, 60);
    rd(OFS_STATUS, 33'h2);
    rd(OFS_FLAGS, 33'h1);
    `CHK(osc_fail_irq, 1'b1, "fail interrupt")
    ext_run <= 1'b1;
    repeat (40) @(posedge pclk);
    rd(OFS_STATUS, 33'h2);
    apb(1'b1, OFS_FLAGS, 32'h1);
    rd(OFS_FLAGS, 33'h0);
    `CHK(osc_fail_irq, 1'b0, "interrupt after clear")
    $display("test fail-safe done");
    apb(1'b1, OFS_CTRL, {24'h0, ifs, 4'h1});
    rd(OFS_STATUS, 33'h0);
    wait_sel(SEL_TOSC, 200);
    rd(OFS_STATUS, 33'h9);
    apb(1'b1, OFS_CTRL, {24'h0, ifs, 4'h0});
    wait_sel(SEL_EXT, 200);
    $display("test source change done");
    pulse(1'b0);
    repeat (2) @(posedge pclk);
    `CHK({startup_done_flag, sys_clk_sel}, {1'b0, SEL_INT}, "sleep entry")
    pulse(1'b1);
    repeat (10) @(posedge pclk);
    pulse(1'b0);
    repeat (60) @(posedge pclk);
    `CHK(startup_done_flag, 1'b0, "sleep aborts start-up")
    pulse(1'b1);
    wait_sel(SEL_EXT, 200);
    $display("test sleep done");
    foreach (cfg[i]) begin
      ext_half <= 3'(2 + $urandom % 2);
      apb(1'b1, OFS_CONFIG, {24'h0, cfg[i]});
      rd(OFS_CONFIG, {25'h0, cfg[i]});
      pulse(1'b0);
      pulse(1'b1);
      repeat (3) @(posedge pclk);
      `CHK(sys_clk_hold, cfg[i][1:0] == 2'b00 && cfg[i][6:4] < MODE_RC, "start-up hold")
      wait_sel(SEL_EXT, 200);
      if (cfg[i][6:4] >= MODE_RC) `CHK(n < OST_N, 1'b1, "no start-up timer")
      ext_run <= 1'b0;
      if (cfg[i][1]) wait_sel(SEL_INT, 60);
      else begin
        repeat (60) @(posedge pclk);
        `CHK(sys_clk_sel, SEL_EXT, "monitor disabled")
      end
      apb(1'b1, OFS_FLAGS, 32'h1);
      ext_run <= 1'b1;
    end
    $display("test oscillator modes done");
    final_report();
  end
endmodule
